/* dmem_addr.sv */
// Data-memory address generation: bank pointer, fast window, full moves and indirect pairs.
// Assumes the core presents one operand access per cycle and holds W outside this block.
`timescale 1ns/10ps
`default_nettype none
module dmem_addr
  import dmem_pkg::*;
#(
  parameter int IMPL_BANKS = 16
)
(
  // Clock and reset.
  input  wire logic                      mclk,
  input  wire logic                      srst,
  // Instruction access port.
  input  wire logic                      acc_valid,
  input  wire logic                      acc_write,
  input  wire dmem_pkg::addr_mode_e      acc_mode,
  input  wire logic [7:0]                acc_offset,
  input  wire logic [11:0]               acc_full_addr,
  input  wire logic [7:0]                acc_wdata,
  input  wire logic [7:0]                w_value,
  // Load-bank-literal.
  input  wire logic                      lit_load,
  input  wire logic [7:0]                lit_value,
  // Read answer.
  output logic      [7:0]                acc_rdata,
  output logic                           flags_update,
  output logic      [11:0]               eff_addr,
  // Register view.
  output logic      [7:0]                bank_pointer
);
  // ====================================================================
  // Bank pointer
  logic [3:0] bank_r;
  logic [3:0] bank_nxt;

  assign bank_pointer = {4'h0, bank_r};

  // ====================================================================
  // Operand address
  wire        win_hi   = acc_offset >= WINDOW_SPLIT;
  wire [3:0]  win_bank = win_hi ? WINDOW_HI_BANK : 4'h0;
  wire [11:0] op_addr  = (acc_mode == MODE_FULL)   ? acc_full_addr :
                         (acc_mode == MODE_WINDOW) ? {win_bank, acc_offset} :
                         {bank_r, acc_offset};

  // ====================================================================
  // Virtual operand decode
  logic [7:0]  plo [NUM_PAIRS];
  logic [7:0]  phi [NUM_PAIRS];
  logic [NUM_PAIRS-1:0] hit_v;
  logic [2:0]  vop [NUM_PAIRS];
  logic [11:0] vbase [NUM_PAIRS];
  logic [11:0] lbase [NUM_PAIRS];

  assign vbase[0] = VIRT_BASE0;
  assign vbase[1] = VIRT_BASE1;
  assign vbase[2] = VIRT_BASE2;
  assign lbase[0] = PTR_LO_BASE0;
  assign lbase[1] = PTR_LO_BASE1;
  assign lbase[2] = PTR_LO_BASE2;

  genvar g;
  generate
    for (g = 0; g < NUM_PAIRS; g++) begin : g_dec
      wire [11:0] d = op_addr - vbase[g];
      assign vop[g]    = d[2:0];
      assign hit_v[g]  = (d < 12'h005);
    end
  endgenerate

  logic [1:0]       sel;
  logic             is_virt;
  virt_kind_e       kind;
  always_comb begin
    sel     = 2'd0;
    is_virt = 1'b0;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      if (hit_v[i]) begin
        sel     = 2'(i);
        is_virt = 1'b1;
      end
    end
  end

  always_comb begin
    kind = VK_NONE;
    if (is_virt) begin
      case (vop[sel])
        VOP_PLAIN:   kind = VK_PLAIN;
        VOP_POST_INCREMENT_OPERAND: kind = VK_POST_INCREMENT_OPERAND;
        VOP_POST_DECREMENT_OPERAND: kind = VK_POST_DECREMENT_OPERAND;
        VOP_PRE_INCREMENT_OPERAND:  kind = VK_PRE_INCREMENT_OPERAND;
        default:     kind = VK_WORKING_OFFSET_OPERAND;
      endcase
    end
  end

  // ====================================================================
  // Indirect address
  wire [11:0] ptr_addr = {phi[sel][3:0], plo[sel]};
  wire [11:0] w_ext    = {{4{w_value[7]}}, w_value};
  wire [11:0] ind_addr = (kind == VK_PRE_INCREMENT_OPERAND) ? ptr_addr + 12'h001 :
                         (kind == VK_WORKING_OFFSET_OPERAND)  ? ptr_addr + w_ext :
                         ptr_addr;

  // Indirect target that itself is a virtual operand gives zero and drops writes.
  logic ind_virt;
  always_comb begin
    ind_virt = 1'b0;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      if ((ind_addr - vbase[i]) < 12'h005) begin
        ind_virt = 1'b1;
      end
    end
  end

  wire        indirect = is_virt;
  wire [11:0] tgt      = indirect ? ind_addr : op_addr;
  wire        tgt_bank = (tgt == BANK_PTR_ADDR);
  logic [NUM_PAIRS-1:0] tgt_lo;
  logic [NUM_PAIRS-1:0] tgt_hi;
  generate
    for (g = 0; g < NUM_PAIRS; g++) begin : g_tgt
      assign tgt_lo[g] = (tgt == lbase[g]);
      assign tgt_hi[g] = (tgt == lbase[g] + 12'h001);
    end
  endgenerate

  wire        blocked = indirect && ind_virt;
  wire        do_wr   = acc_valid && acc_write && !blocked;
  wire        sfr_hit = tgt_bank || (|tgt_lo) || (|tgt_hi);

  // ====================================================================
  // Pointer pairs
  generate
    for (g = 0; g < NUM_PAIRS; g++) begin : g_pair
      wire own  = acc_valid && indirect && (sel == 2'(g));
      wire upd  = own && !(do_wr && (tgt_lo[g] || tgt_hi[g]));
      ptr_pair u_pair (
        .mclk     (mclk),
        .srst     (srst),
        .wr_lo    (do_wr && tgt_lo[g]),
        .wr_hi    (do_wr && tgt_hi[g]),
        .wdata    (acc_wdata),
        .step_inc (upd && (kind == VK_POST_INCREMENT_OPERAND || kind == VK_PRE_INCREMENT_OPERAND)),
        .step_dec (upd && (kind == VK_POST_DECREMENT_OPERAND)),
        .plain_wr (own && do_wr && tgt_lo[g]),
        .ptr_lo   (plo[g]),
        .ptr_hi   (phi[g])
      );
    end
  endgenerate

  // ====================================================================
  // RAM and read mux
  logic [7:0] ram_rdata;
  data_ram #(
    .IMPL_BANKS (IMPL_BANKS)
  ) u_ram (
    .mclk  (mclk),
    .wr_en (do_wr && !sfr_hit),
    .addr  (tgt),
    .wdata (acc_wdata),
    .rdata (ram_rdata)
  );

  logic [7:0] sfr_rdata;
  always_comb begin
    sfr_rdata = {4'h0, bank_r};
    for (int i = 0; i < NUM_PAIRS; i++) begin
      if (tgt_lo[i]) begin
        sfr_rdata = plo[i];
      end else if (tgt_hi[i]) begin
        sfr_rdata = phi[i];
      end
    end
  end

  assign acc_rdata    = blocked ? 8'h00 : (sfr_hit ? sfr_rdata : ram_rdata);
  assign flags_update = acc_valid;
  assign eff_addr     = tgt;

  // ====================================================================
  // Bank pointer update
  always_comb begin
    bank_nxt = bank_r;
    if (lit_load) begin
      bank_nxt = lit_value[3:0] & BANK_PTR_MASK;
    end else if (do_wr && tgt_bank) begin
      bank_nxt = acc_wdata[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bank_r <= BANK_PTR_RST[3:0];
    end else begin
      bank_r <= bank_nxt;
    end
  end
endmodule
`default_nettype wire

/* dmem_pkg.sv */
// Constants, types and field layouts for the banked data-memory addressing block.
// Assumes a single core clock and a core instruction decoder that drives the access port.
// Operation
// - Byte-wide RAM space with 12-bit address.
// - Sixteen 256-byte banks; small variant implements eight.
// - Unimplemented locations read as zero.
// - Fast window reaches registers without bank pointer.
// - Banked address is bank pointer plus offset.
// - Bank pointer upper nibble reads zero, ignores writes.
// - Load-bank-literal writes literal into bank pointer.
// - Unimplemented bank writes dropped, reads give zero.
// - Flags update as if access succeeded.
// - Full-address move uses 12-bit addresses, ignores pointer.
// - Other instructions complete address via pointer or window.
// - Post-decrement uses pointer, then decrements it.
// - Post-increment uses pointer, then increments it.
// - Pre-increment increments pointer, then uses it.
// - Offset operand adds signed working register.
// - Plain indirect uses pointer, leaves it unchanged.
// - Indirect access to virtual operand reads zero.
// - Increments and decrements carry across whole pair.
// - Pointer auto-updates leave status flags unchanged.
// - Virtual-operand write to pair stores value unmodified.
// - Pointer pairs are directly readable, writable registers.
// - Indirect access reaches all other special registers.
`default_nettype none
package dmem_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int OFS_W  = 8;
  localparam int NUM_PAIRS = 3;

  // Window split: low offsets go to bank 0, high offsets to bank 15.
  localparam logic [7:0] WINDOW_SPLIT = 8'h60;
  localparam logic [3:0] WINDOW_HI_BANK = 4'hF;

  // Special-function addresses of the pointer pairs and the bank pointer.
  localparam logic [11:0] BANK_PTR_ADDR = 12'hFE0;
  localparam logic [11:0] W_REG_ADDR    = 12'hFE8;
  localparam logic [11:0] VIRT_BASE0    = 12'hFEB;
  localparam logic [11:0] VIRT_BASE1    = 12'hFE3;
  localparam logic [11:0] VIRT_BASE2    = 12'hFDB;
  localparam logic [11:0] PTR_LO_BASE0  = 12'hFE9;
  localparam logic [11:0] PTR_LO_BASE1  = 12'hFE1;
  localparam logic [11:0] PTR_LO_BASE2  = 12'hFD9;

  // Offsets of the five virtual operands above the virtual base of each pair.
  localparam logic [2:0] VOP_WORKING_OFFSET_OPERAND   = 3'h0;
  localparam logic [2:0] VOP_PRE_INCREMENT_OPERAND  = 3'h1;
  localparam logic [2:0] VOP_POST_DECREMENT_OPERAND = 3'h2;
  localparam logic [2:0] VOP_POST_INCREMENT_OPERAND = 3'h3;
  localparam logic [2:0] VOP_PLAIN   = 3'h4;

  localparam logic [7:0] BANK_PTR_RST = 8'h00;
  localparam logic [7:0] PTR_RST      = 8'h00;
  localparam logic [3:0] BANK_PTR_MASK = 4'hF;

  typedef enum logic [1:0] {
    MODE_BANKED,
    MODE_WINDOW,
    MODE_FULL
  } addr_mode_e;

  typedef enum logic [2:0] {
    VK_NONE,
    VK_PLAIN,
    VK_POST_INCREMENT_OPERAND,
    VK_POST_DECREMENT_OPERAND,
    VK_PRE_INCREMENT_OPERAND,
    VK_WORKING_OFFSET_OPERAND
  } virt_kind_e;

endpackage
`default_nettype wire

/* ptr_pair.sv */
// One indirect pointer pair with its auto-update logic.
// Assumes the parent decodes which pair is written and which virtual operand is used.
`timescale 1ns/10ps
`default_nettype none
module ptr_pair
  import dmem_pkg::*;
(
  // Clock and reset.
  input  wire logic                 mclk,
  input  wire logic                 srst,
  // Direct byte writes.
  input  wire logic                 wr_lo,
  input  wire logic                 wr_hi,
  input  wire logic [DATA_W-1:0]    wdata,
  // Auto update.
  input  wire logic                 step_inc,
  input  wire logic                 step_dec,
  input  wire logic                 plain_wr,
  // Pair value.
  output logic      [DATA_W-1:0]    ptr_lo,
  output logic      [DATA_W-1:0]    ptr_hi
);
  logic [15:0] pair_r;
  logic [15:0] pair_nxt;

  assign ptr_lo = pair_r[7:0];
  assign ptr_hi = pair_r[15:8];

  always_comb begin
    pair_nxt = pair_r;
    if (plain_wr) begin
      pair_nxt = {pair_r[15:8], wdata};
    end else if (wr_lo) begin
      pair_nxt[7:0] = wdata;
    end else if (wr_hi) begin
      pair_nxt[15:8] = wdata;
    end else if (step_inc) begin
      pair_nxt = pair_r + 16'h0001;
    end else if (step_dec) begin
      pair_nxt = pair_r - 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pair_r <= {PTR_RST, PTR_RST};
    end else begin
      pair_r <= pair_nxt;
    end
  end
endmodule
`default_nettype wire

/* data_ram.sv */
// Byte-wide data RAM with a number of implemented banks.
// Assumes one access per cycle; unimplemented banks read zero and drop writes.
`timescale 1ns/10ps
`default_nettype none
module data_ram
  import dmem_pkg::*;
#(
  parameter int IMPL_BANKS = 16
)
(
  // Clock.
  input  wire logic                 mclk,
  // Access.
  input  wire logic                 wr_en,
  input  wire logic [ADDR_W-1:0]    addr,
  input  wire logic [DATA_W-1:0]    wdata,
  output logic      [DATA_W-1:0]    rdata
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  wire               bank_ok = 32'(addr[11:8]) < IMPL_BANKS;

  assign rdata = bank_ok ? mem[addr] : 8'h00;

  always_ff @(posedge mclk) begin
    if (wr_en && bank_ok) begin
      mem[addr] <= wdata;
    end
  end
endmodule
`default_nettype wire

/* dmem_addr_monitor.sv */
// Assertion checker for the data-memory addressing block.
// Assumes it is bound to dmem_addr and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module dmem_addr_monitor
  import dmem_pkg::*;
#(
  parameter int IMPL_BANKS = 16
)
(
  // Clock and reset.
  input wire logic                 mclk,
  input wire logic                 srst,
  // Access port.
  input wire logic                 acc_valid,
  input wire logic                 acc_write,
  input wire dmem_pkg::addr_mode_e acc_mode,
  input wire logic [7:0]           acc_offset,
  input wire logic [11:0]          acc_full_addr,
  input wire logic [7:0]           acc_wdata,
  input wire logic                 lit_load,
  input wire logic [7:0]           lit_value,
  // Answers.
  input wire logic [7:0]           acc_rdata,
  input wire logic                 flags_update,
  input wire logic [11:0]          eff_addr,
  input wire logic [7:0]           bank_pointer
);
  // ==========
  // Helpers and properties.
  logic [3:0] lit_q;
  always_ff @(posedge mclk) begin
    lit_q <= lit_value[3:0];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence wr_full_s;
    acc_valid && acc_write && acc_mode == MODE_FULL && int'(acc_full_addr[11:8]) < IMPL_BANKS;
  endsequence
  bank_upper_a: assert property (bank_pointer[7:4] == 4'h0)
    else $error("bank pointer upper bits set");
  lit_load_a: assert property (lit_load |=> bank_pointer == {4'h0, lit_q})
    else $error("bank pointer not loaded from literal");
  bank_hold_a: assert property (!lit_load && !acc_valid |=> $stable(bank_pointer))
    else $error("bank pointer changed while idle");
  flags_a: assert property (flags_update == acc_valid)
    else $error("flag update missing");
  banked_addr_a: assert property (acc_valid && acc_mode == MODE_BANKED && bank_pointer[3:0] != 4'hF
    |-> eff_addr == {bank_pointer[3:0], acc_offset}) else $error("banked address wrong");
  window_addr_a: assert property (acc_valid && acc_mode == MODE_WINDOW && acc_offset < WINDOW_SPLIT
    |-> eff_addr == {4'h0, acc_offset}) else $error("window address wrong");
  full_addr_a: assert property (acc_valid && acc_mode == MODE_FULL && acc_full_addr[11:8] != 4'hF
    |-> eff_addr == acc_full_addr) else $error("full address wrong");
  unimpl_read_a: assert property (acc_valid && !acc_write && eff_addr[11:8] != 4'hF
    && int'(eff_addr[11:8]) >= IMPL_BANKS |-> acc_rdata == 8'h00) else $error("unimplemented read not zero");
  ram_round_a: assert property (wr_full_s ##1 (acc_valid && !acc_write && acc_full_addr == $past(acc_full_addr)
    && acc_mode == MODE_FULL) |-> acc_rdata == $past(acc_wdata)) else $error("stored byte lost");
  cover property (lit_load);
  cover property (acc_valid && acc_write && acc_mode == MODE_BANKED);
  cover property (acc_valid && acc_mode == MODE_WINDOW);
endmodule
bind dmem_addr dmem_addr_monitor #(.IMPL_BANKS(IMPL_BANKS)) mon_u (.mclk(mclk), .srst(srst),
  .acc_valid(acc_valid), .acc_write(acc_write), .acc_mode(acc_mode), .acc_offset(acc_offset),
  .acc_full_addr(acc_full_addr), .acc_wdata(acc_wdata), .lit_load(lit_load), .lit_value(lit_value),
  .acc_rdata(acc_rdata), .flags_update(flags_update), .eff_addr(eff_addr), .bank_pointer(bank_pointer));
`default_nettype wire

/* core_model.sv */
// Core-side model issuing operand accesses and load-bank-literal pulses.
// Assumes mclk runs free; requests change only at its falling edge.
`timescale 1ns/10ps
`default_nettype none
module core_model
  import dmem_pkg::*;
(
  // Clock.
  input  wire logic            mclk,
  // Requests.
  output logic                 acc_valid,
  output logic                 acc_write,
  output dmem_pkg::addr_mode_e acc_mode,
  output logic [7:0]           acc_offset,
  output logic [11:0]          acc_full_addr,
  output logic [7:0]           acc_wdata,
  output logic [7:0]           w_value,
  output logic                 lit_load,
  output logic [7:0]           lit_value,
  // Answers.
  input  wire logic [7:0]      acc_rdata,
  input  wire logic [11:0]     eff_addr
);
  // ==========
  // Request tasks.
  logic [7:0]  rd;
  logic [11:0] ea;
  initial begin
    {acc_valid, acc_write, lit_load, acc_offset, acc_full_addr} = '0;
    {acc_wdata, w_value, lit_value} = '0;
    acc_mode = MODE_BANKED;
  end
  // The answer is combinational, so it is taken just before the edge that retires the access.
  task automatic acc(input logic wr, input addr_mode_e m, input logic [11:0] a, input logic [7:0] d,
                     input logic [7:0] w);
    @(negedge mclk);
    lit_load = 1'b0;
    acc_valid = 1'b1;
    acc_write = wr;
    acc_mode = m;
    acc_offset = a[7:0];
    acc_full_addr = a;
    acc_wdata = d;
    w_value = w;
    #2;
    rd = acc_rdata;
    ea = eff_addr;
  endtask
  task automatic lit(input logic [7:0] v);
    @(negedge mclk);
    acc_valid = 1'b0;
    lit_load = 1'b1;
    lit_value = v;
  endtask
  // Released lines show inverted values so stale data is never mistaken for a request.
  task automatic idle();
    @(negedge mclk);
    acc_valid = 1'b0;
    lit_load = 1'b0;
    {acc_offset, acc_full_addr, acc_wdata} = ~{acc_offset, acc_full_addr, acc_wdata};
  endtask
endmodule
`default_nettype wire

/* banked_data_memory_addressing_tb_top.sv */
// Testbench top for the banked data-memory addressing block.
// Assumes core_model drives all requests; eight banks are implemented.
`timescale 1ns/10ps
`default_nettype none
module banked_data_memory_addressing_tb_top;
  import dmem_pkg::*;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        acc_valid, acc_write, lit_load, flags_update;
  addr_mode_e  acc_mode;
  logic [7:0]  acc_offset, acc_wdata, w_value, lit_value, acc_rdata, bank_pointer;
  logic [11:0] acc_full_addr, eff_addr;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #2.5 mclk = ~mclk;
  core_model core_u (.mclk(mclk), .acc_valid(acc_valid), .acc_write(acc_write), .acc_mode(acc_mode),
    .acc_offset(acc_offset), .acc_full_addr(acc_full_addr), .acc_wdata(acc_wdata), .w_value(w_value),
    .lit_load(lit_load), .lit_value(lit_value), .acc_rdata(acc_rdata), .eff_addr(eff_addr));
  dmem_addr #(.IMPL_BANKS(8)) dut_u (.mclk(mclk), .srst(srst), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_mode(acc_mode), .acc_offset(acc_offset), .acc_full_addr(acc_full_addr), .acc_wdata(acc_wdata),
    .w_value(w_value), .lit_load(lit_load), .lit_value(lit_value), .acc_rdata(acc_rdata),
    .flags_update(flags_update), .eff_addr(eff_addr), .bank_pointer(bank_pointer));
  // ==========
  // Access and compare tasks.
  task automatic tally_and_finish();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_full(input logic [11:0] a, input logic [7:0] d);
    core_u.acc(1'b1, MODE_FULL, a, d, 8'h00);
  endtask
  task automatic chk_last(input logic [7:0] e);
    cmp({4'h0, core_u.rd}, {4'h0, e});
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
    core_u.acc(1'b0, MODE_FULL, a, 8'h00, 8'h00);
    chk_last(e);
  endtask
  task automatic chk_ea(input addr_mode_e m, input logic [11:0] a, input logic [7:0] w, input logic [11:0] e);
    core_u.acc(1'b0, m, a, 8'h00, w);
    cmp(core_u.ea, e);
  endtask
  task automatic chk_bp(input logic [7:0] e);
    cmp({4'h0, bank_pointer}, {4'h0, e});
  endtask
  // Looks at the flag strobe while the last access still stands.
  task automatic chk_flags(input logic e);
    cmp({11'h000, flags_update}, {11'h000, e});
  endtask
  initial begin
    #2000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    chk_bp(8'h00);
    core_u.lit(8'hA5);
    core_u.idle();
    chk_bp(8'h05);
    core_u.acc(1'b1, MODE_BANKED, 12'h010, 8'h3C, 8'h00);
    chk_rd(12'h510, 8'h3C);
    wr_full(12'h010, 8'h77);
    chk_rd(12'h010, 8'h77);
    chk_ea(MODE_WINDOW, 12'h010, 8'h00, 12'h010);
    chk_last(8'h77);
    chk_ea(MODE_WINDOW, 12'h080, 8'h00, 12'hF80);
    chk_ea(MODE_BANKED, 12'h080, 8'h00, 12'h580);
    wr_full(12'h7FF, 8'hC3);
    chk_rd(12'h7FF, 8'hC3);
    wr_full(12'h800, 8'h55);
    chk_rd(12'h800, 8'h00);
    chk_flags(1'b1);
    wr_full(12'h1FF, 8'h9A);
    wr_full(12'hFE9, 8'hFF);
    wr_full(12'hFEA, 8'h01);
    chk_ea(MODE_FULL, 12'hFEE, 8'h00, 12'h1FF);
    chk_rd(12'hFE9, 8'h00);
    chk_rd(12'hFEA, 8'h02);
    chk_ea(MODE_FULL, 12'hFEF, 8'h00, 12'h200);
    chk_ea(MODE_FULL, 12'hFED, 8'h00, 12'h200);
    chk_ea(MODE_FULL, 12'hFEC, 8'h00, 12'h200);
    chk_ea(MODE_FULL, 12'hFEB, 8'hFF, 12'h1FF);
    chk_last(8'h9A);
    chk_ea(MODE_FULL, 12'hFEF, 8'h00, 12'h200);
    wr_full(12'h000, 8'h5A);
    wr_full(12'hFE9, 8'hE7);
    wr_full(12'hFEA, 8'h0F);
    chk_rd(12'hFEF, 8'h00);
    wr_full(12'hFEF, 8'h11);
    chk_rd(12'h000, 8'h5A);
    wr_full(12'hFE9, 8'hE9);
    wr_full(12'hFEE, 8'h33);
    chk_rd(12'hFE9, 8'h33);
    chk_rd(12'hFEA, 8'h0F);
    wr_full(12'hFE9, 8'hE0);
    wr_full(12'hFEF, 8'hF3);
    core_u.idle();
    chk_bp(8'h03);
    tally_and_finish();
  end
endmodule
`default_nettype wire
